// [rtl/sensor_regs_pkg.sv]
// register map, field positions and reset values of the sensor register bank
// assumes: one byte-wide register space behind a serial engine, one clock
package sensor_regs_pkg;

    // byte addresses of the register map
    localparam logic [7:0] ADDR_TEMP_LOW  = 8'h00;
    localparam logic [7:0] ADDR_TEMP_HIGH = 8'h01;
    localparam logic [7:0] ADDR_RH_LOW    = 8'h02;
    localparam logic [7:0] ADDR_RH_HIGH   = 8'h03;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_TEMP_PEAK = 8'h05;
    localparam logic [7:0] ADDR_RH_PEAK   = 8'h06;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h07;
    localparam logic [7:0] ADDR_TEMP_TRIM = 8'h08;
    localparam logic [7:0] ADDR_RH_TRIM   = 8'h09;
    localparam logic [7:0] ADDR_CONFIG    = 8'h0E;

    // status and interrupt enable bit positions
    localparam int BIT_DONE    = 7;
    localparam int BIT_TEMP_HI = 6;
    localparam int BIT_TEMP_LO = 5;
    localparam int BIT_RH_HI   = 4;
    localparam int BIT_RH_LO   = 3;

    // configuration bit positions
    localparam int CFG_SOFT_BIT  = 7;
    localparam int CFG_DRIVE_BIT = 2;
    localparam int CFG_POL_BIT   = 1;

    // reset values and result layout
    localparam logic [7:0]  ZERO_BYTE   = 8'h00;
    localparam logic [15:0] ZERO_WORD   = 16'h0000;
    localparam logic [15:0] RESULT_CEIL = 16'hFFFC;
    localparam logic [4:0]  ZERO_FLAGS  = 5'h00;
    localparam logic [6:0]  ZERO_CFG    = 7'h00;
    localparam int          CODE_BITS   = 14;
    localparam int          PAD_BITS    = 2;
    localparam int          TRIM_SHIFT  = 6;

endpackage

// [rtl/trim_adder.sv]
// offset trim: adds a signed byte trim to a left-aligned conversion code
// assumes: combinational use, result registered by the caller
`timescale 1ns/1ps
module trim_adder
    import sensor_regs_pkg::*;
#(
    parameter int CODE_W = CODE_BITS,
    parameter int TRIM_W = 8
) (
    // inputs
    input  wire logic [CODE_W-1:0] raw_code,
    input  wire logic [TRIM_W-1:0] trim,
    // trimmed, clamped result
    output logic      [15:0]       result
);

    logic [17:0] code_ext;
    logic [17:0] trim_ext;
    logic [17:0] sum;

    if (CODE_W + PAD_BITS != 16 || TRIM_W + TRIM_SHIFT > 17) begin : g_chk
        $error("trim_adder: unsupported widths");
    end

    // msb of trim carries negative weight, one trim lsb is 16 codes (64 after left alignment)
    assign code_ext = {2'b00, raw_code, {PAD_BITS{1'b0}}};
    assign trim_ext = {{(18 - TRIM_W - TRIM_SHIFT){trim[TRIM_W-1]}}, trim, {TRIM_SHIFT{1'b0}}};
    assign sum      = code_ext + trim_ext;

    // clamp rather than wrap, so a trim never flips hot into cold
    always_comb begin
        if (sum[17]) begin
            result = ZERO_WORD;
        end else if (sum[16]) begin
            result = RESULT_CEIL;
        end else begin
            result = {sum[15:PAD_BITS], {PAD_BITS{1'b0}}};
        end
    end

endmodule

// [rtl/peak_tracker.sv]
// peak detector: keeps the largest 8-bit code since reset or last write
// assumes: sample and write strobes are single-cycle, same clock
`timescale 1ns/1ps
module peak_tracker
    import sensor_regs_pkg::*;
#(
    parameter int CODE_W = 8
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              blk_rst,
    // new sample
    input  wire logic              sample_valid,
    input  wire logic [CODE_W-1:0] sample_code,
    // host write
    input  wire logic              wr_en,
    input  wire logic [CODE_W-1:0] wr_data,
    // stored peak
    output logic      [CODE_W-1:0] peak
);

    if (CODE_W != 8) begin : g_chk
        $error("peak_tracker: register is one byte wide");
    end

    // a host write wins over a sample in the same cycle
    always_ff @(posedge core_clk) begin
        if (blk_rst) begin
            peak <= ZERO_BYTE;
        end else if (wr_en) begin
            peak <= wr_data;
        end else if (sample_valid && sample_code > peak) begin
            peak <= sample_code;
        end
    end

    a_peak_no_drop: assert property (@(posedge core_clk) disable iff (blk_rst)
        !wr_en |=> peak >= $past(peak))
        else $error("peak fell without a write");

    a_peak_catch: assert property (@(posedge core_clk) disable iff (blk_rst)
        sample_valid && !wr_en |=> peak >= $past(sample_code))
        else $error("peak missed a larger sample");

    a_peak_erase: assert property (@(posedge core_clk) disable iff (blk_rst)
        wr_en && wr_data == ZERO_BYTE |=> peak == ZERO_BYTE)
        else $error("zero write did not erase peak");

endmodule

// [rtl/climate_sensor_regs.sv]
// result, status, peak, interrupt enable and trim registers of the sensor
// assumes: serial engine gives byte strobes on core_clk; converter gives
// one-cycle conv_done with codes and threshold compares on the same clock
`timescale 1ns/1ps
module climate_sensor_regs
    import sensor_regs_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // byte side of the serial engine
    input  wire logic        ptr_load,
    input  wire logic [7:0]  ptr_byte,
    input  wire logic        wr_strobe,
    input  wire logic [7:0]  wr_byte,
    input  wire logic        rd_strobe,
    output logic      [7:0]  rd_byte,
    output logic             reg_hit,
    // converter side
    input  wire logic        conv_done,
    input  wire logic [13:0] conv_temp,
    input  wire logic [13:0] conv_rh,
    input  wire logic        temp_above,
    input  wire logic        temp_below,
    input  wire logic        rh_above,
    input  wire logic        rh_below,
    // alert pin
    output logic             alert_pin,
    output logic             alert_pin_drive_n,
    // configuration towards the rest of the device
    output logic      [6:0]  cfg_bits,
    output logic             nv_reload
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0]  ptr;
    logic [15:0] temp_result;
    logic [15:0] rh_result;
    logic [15:0] temp_trimmed;
    logic [15:0] rh_trimmed;
    logic [7:3]  flags;
    logic [7:3]  flag_set;
    logic [7:3]  flag_clr;
    logic [7:3]  irq_en;
    logic [7:0]  temp_trim_value;
    logic [7:0]  rh_trim_value;
    logic [7:0]  temp_peak_code;
    logic [7:0]  rh_peak_code;
    logic [6:0]  cfg;
    logic        soft_restart_bit;
    logic        blk_rst;
    logic        status_rd;
    logic        result_rd;
    logic        alert_active;
    logic [7:0]  next_rd_byte;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic is_result_addr(input logic [7:0] addr);
        return addr == ADDR_TEMP_LOW || addr == ADDR_TEMP_HIGH ||
               addr == ADDR_RH_LOW || addr == ADDR_RH_HIGH;
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        return addr <= ADDR_RH_TRIM || addr == ADDR_CONFIG;
    endfunction

    function automatic logic write_at(input logic strobe, input logic [7:0] addr,
                                      input logic [7:0] target);
        return strobe && addr == target;
    endfunction

    // soft reset runs the same path as the power-up reset
    assign blk_rst   = sys_rst || soft_restart_bit;
    assign status_rd = rd_strobe && ptr == ADDR_STATUS;
    assign result_rd = rd_strobe && is_result_addr(ptr);
    assign reg_hit   = is_mapped(ptr);

    ////////////////////////////////////////////////////////////////////////////
    // register pointer

    // the pointer survives a soft reset; it belongs to the serial engine
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ptr <= ZERO_BYTE;
        end else if (ptr_load) begin
            ptr <= ptr_byte;
        end else if (wr_strobe || rd_strobe) begin
            ptr <= 8'(ptr + 8'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion results with offset trim

    // code scale fixed by the converter; trims line up with it at 16 codes per lsb (64 in the left-aligned 16-bit result)
    trim_adder #(
        .CODE_W (CODE_BITS),
        .TRIM_W (8)
    ) u_temp_trim (
        .raw_code (conv_temp),
        .trim     (temp_trim_value),
        .result   (temp_trimmed)
    );

    trim_adder #(
        .CODE_W (CODE_BITS),
        .TRIM_W (8)
    ) u_rh_trim (
        .raw_code (conv_rh),
        .trim     (rh_trim_value),
        .result   (rh_trimmed)
    );

    always_ff @(posedge core_clk) begin
        if (blk_rst) begin
            temp_result <= ZERO_WORD;
            rh_result   <= ZERO_WORD;
        end else if (conv_done) begin
            temp_result <= temp_trimmed;
            rh_result   <= rh_trimmed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags

    assign flag_set = conv_done ? {1'b1, temp_above, temp_below, rh_above, rh_below} : ZERO_FLAGS;

    // the read returns the snapshot taken before this edge, so clearing
    // what was set is exactly what was reported
    always_comb begin
        flag_clr            = status_rd ? flags : ZERO_FLAGS;
        flag_clr[BIT_DONE]  = (status_rd || result_rd) && flags[BIT_DONE];
    end

    for (genvar i = BIT_RH_LO; i <= BIT_DONE; i++) begin : g_flag
        // set beats clear, so an event in the read cycle stays pending
        always_ff @(posedge core_clk) begin
            if (blk_rst) begin
                flags[i] <= 1'b0;
            end else if (flag_set[i]) begin
                flags[i] <= 1'b1;
            end else if (flag_clr[i]) begin
                flags[i] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peak detectors

    peak_tracker #(
        .CODE_W (8)
    ) u_temp_peak (
        .core_clk     (core_clk),
        .blk_rst      (blk_rst),
        .sample_valid (conv_done),
        .sample_code  (temp_trimmed[15:8]),
        .wr_en        (write_at(wr_strobe, ptr, ADDR_TEMP_PEAK)),
        .wr_data      (wr_byte),
        .peak         (temp_peak_code)
    );

    peak_tracker #(
        .CODE_W (8)
    ) u_rh_peak (
        .core_clk     (core_clk),
        .blk_rst      (blk_rst),
        .sample_valid (conv_done),
        .sample_code  (rh_trimmed[15:8]),
        .wr_en        (write_at(wr_strobe, ptr, ADDR_RH_PEAK)),
        .wr_data      (wr_byte),
        .peak         (rh_peak_code)
    );

    ////////////////////////////////////////////////////////////////////////////
    // writable control registers

    always_ff @(posedge core_clk) begin
        if (blk_rst) begin
            irq_en <= ZERO_FLAGS;
        end else if (write_at(wr_strobe, ptr, ADDR_IRQ_EN)) begin
            irq_en <= wr_byte[7:3];
        end
    end

    always_ff @(posedge core_clk) begin
        if (blk_rst) begin
            temp_trim_value <= ZERO_BYTE;
            rh_trim_value   <= ZERO_BYTE;
        end else begin
            if (write_at(wr_strobe, ptr, ADDR_TEMP_TRIM)) begin
                temp_trim_value <= wr_byte;
            end
            if (write_at(wr_strobe, ptr, ADDR_RH_TRIM)) begin
                rh_trim_value <= wr_byte;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (blk_rst) begin
            cfg <= ZERO_CFG;
        end else if (write_at(wr_strobe, ptr, ADDR_CONFIG)) begin
            cfg <= wr_byte[6:0];
        end
    end

    // one-cycle pulse that ends by itself; it resets everything on blk_rst except the pointer and rd_byte
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            soft_restart_bit <= 1'b0;
        end else begin
            soft_restart_bit <= write_at(wr_strobe, ptr, ADDR_CONFIG) && wr_byte[CFG_SOFT_BIT];
        end
    end

    assign cfg_bits  = cfg;
    assign nv_reload = soft_restart_bit;

    ////////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        case (ptr)
            ADDR_TEMP_LOW:  next_rd_byte = temp_result[7:0];
            ADDR_TEMP_HIGH: next_rd_byte = temp_result[15:8];
            ADDR_RH_LOW:    next_rd_byte = rh_result[7:0];
            ADDR_RH_HIGH:   next_rd_byte = rh_result[15:8];
            ADDR_STATUS:    next_rd_byte = {flags, 3'b000};
            ADDR_TEMP_PEAK: next_rd_byte = temp_peak_code;
            ADDR_RH_PEAK:   next_rd_byte = rh_peak_code;
            ADDR_IRQ_EN:    next_rd_byte = {irq_en, 3'b000};
            ADDR_TEMP_TRIM: next_rd_byte = temp_trim_value;
            ADDR_RH_TRIM:   next_rd_byte = rh_trim_value;
            ADDR_CONFIG:    next_rd_byte = {1'b0, cfg};
            default:        next_rd_byte = ZERO_BYTE;
        endcase
    end

    // not touched by soft reset so an in-flight answer is not torn
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_byte <= ZERO_BYTE;
        end else if (rd_strobe) begin
            rd_byte <= next_rd_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alert pin

    // done uses plain sense, threshold gates use inverted sense
    assign alert_active = (flags[BIT_DONE] && irq_en[BIT_DONE]) ||
                          |(flags[BIT_TEMP_HI:BIT_RH_LO] & ~irq_en[BIT_TEMP_HI:BIT_RH_LO]);

    always_ff @(posedge core_clk) begin
        if (blk_rst) begin
            alert_pin         <= 1'b1;
            alert_pin_drive_n <= 1'b1;
        end else begin
            alert_pin         <= cfg[CFG_POL_BIT] ? alert_active : !alert_active;
            alert_pin_drive_n <= !cfg[CFG_DRIVE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (blk_rst);

    sequence s_status_read;
        status_rd && !conv_done;
    endsequence

    sequence s_flags_gone;
        flags == ZERO_FLAGS;
    endsequence

    a_done_sets: assert property (conv_done |=> flags[BIT_DONE])
        else $error("done flag not set after conversion");

    a_status_clears: assert property (s_status_read |=> s_flags_gone)
        else $error("status read left flags set");

    a_result_clears: assert property (result_rd && !conv_done |=> !flags[BIT_DONE])
        else $error("result read left done flag set");

    a_snapshot_read: assert property (status_rd |=> rd_byte == {$past(flags), 3'b000})
        else $error("status answer is not the snapshot");

    a_event_kept: assert property (status_rd && conv_done |=> flags == $past(flag_set))
        else $error("event lost during status read");

    a_low_bits_zero: assert property (temp_result[1:0] == 2'b00 && rh_result[1:0] == 2'b00)
        else $error("result low bits not zero");

    a_result_stored: assert property (conv_done |=> temp_result == $past(temp_trimmed)
                                      && rh_result == $past(rh_trimmed))
        else $error("trimmed result not stored");

    a_alert_hiz: assert property (!cfg[CFG_DRIVE_BIT] |=> alert_pin_drive_n)
        else $error("alert driven while disabled");

    a_alert_follows: assert property (cfg[CFG_POL_BIT] && alert_active |=> alert_pin)
        else $error("alert pin does not follow flags");

    a_ptr_step: assert property ((rd_strobe || wr_strobe) && !ptr_load
                                 |=> ptr == 8'($past(ptr) + 8'h01))
        else $error("pointer did not advance");

    a_soft_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        soft_restart_bit |=> !soft_restart_bit && cfg == ZERO_CFG && temp_result == ZERO_WORD
                             && temp_peak_code == ZERO_BYTE)
        else $error("soft reset did not clear registers");

    a_reserved_zero: assert property (rd_strobe && (ptr == ADDR_STATUS || ptr == ADDR_IRQ_EN)
                                      |=> rd_byte[2:0] == 3'b000)
        else $error("reserved bits read nonzero");

endmodule

// [bench/host_byte_model.sv]
// host side of the register port: pointer load, byte write, byte read
// assumes: strobes taken on the rising edge, read data valid one cycle later
`timescale 1ns/1ps
module host_byte_model (
    // clock
    input  wire logic       core_clk,
    // register port
    output logic            ptr_load,
    output logic [7:0]      ptr_byte,
    output logic            wr_strobe,
    output logic [7:0]      wr_byte,
    output logic            rd_strobe,
    input  wire logic [7:0] rd_byte
);
    // released lines show the inverse so stale data never looks valid
    initial begin
        ptr_load  = 1'b0;
        ptr_byte  = 8'hA5;
        wr_strobe = 1'b0;
        wr_byte   = 8'h5A;
        rd_strobe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one idle cycle between requests, so no signal changes twice at once
    task automatic point(input logic [7:0] a);
        @(negedge core_clk);
        ptr_load = 1'b1;
        ptr_byte = a;
        @(negedge core_clk);
        ptr_load = 1'b0;
        ptr_byte = ~a;
    endtask

    task automatic write(input logic [7:0] d);
        @(negedge core_clk);
        wr_strobe = 1'b1;
        wr_byte   = d;
        @(negedge core_clk);
        wr_strobe = 1'b0;
        wr_byte   = ~d;
    endtask

    task automatic read(output logic [7:0] d);
        @(negedge core_clk);
        rd_strobe = 1'b1;
        @(negedge core_clk);
        d         = rd_byte;
        rd_strobe = 1'b0;
    endtask
endmodule

// [bench/tb_climate_sensor_regs.sv]
// self-checking bench of the sensor register bank
// assumes: host model drives the register port, bench drives the converter
`timescale 1ns/1ps
module tb_climate_sensor_regs
    import sensor_regs_pkg::*;
;
    logic        core_clk;
    logic        sys_rst;
    logic        ptr_load;
    logic [7:0]  ptr_byte;
    logic        wr_strobe;
    logic [7:0]  wr_byte;
    logic        rd_strobe;
    logic [7:0]  rd_byte;
    logic        reg_hit;
    logic        conv_done;
    logic [13:0] conv_temp;
    logic [13:0] conv_rh;
    logic        temp_above;
    logic        temp_below;
    logic        rh_above;
    logic        rh_below;
    logic        alert_pin;
    logic        alert_pin_drive_n;
    logic [6:0]  cfg_bits;
    logic        nv_reload;
    int          num_errors;
    int          n_tests;

    climate_sensor_regs dut_u (
        .core_clk          (core_clk),
        .sys_rst           (sys_rst),
        .ptr_load          (ptr_load),
        .ptr_byte          (ptr_byte),
        .wr_strobe         (wr_strobe),
        .wr_byte           (wr_byte),
        .rd_strobe         (rd_strobe),
        .rd_byte           (rd_byte),
        .reg_hit           (reg_hit),
        .conv_done         (conv_done),
        .conv_temp         (conv_temp),
        .conv_rh           (conv_rh),
        .temp_above        (temp_above),
        .temp_below        (temp_below),
        .rh_above          (rh_above),
        .rh_below          (rh_below),
        .alert_pin         (alert_pin),
        .alert_pin_drive_n (alert_pin_drive_n),
        .cfg_bits          (cfg_bits),
        .nv_reload         (nv_reload)
    );

    host_byte_model host_u (
        .core_clk  (core_clk),
        .ptr_load  (ptr_load),
        .ptr_byte  (ptr_byte),
        .wr_strobe (wr_strobe),
        .wr_byte   (wr_byte),
        .rd_strobe (rd_strobe),
        .rd_byte   (rd_byte)
    );

    always #12.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic expect_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.point(a);
        host_u.read(d);
        check(name, {8'h00, d}, {8'h00, exp});
    endtask

    // threshold inputs only count alongside the done pulse
    task automatic convert(input logic [13:0] t, input logic [13:0] h, input logic [3:0] f);
        @(negedge core_clk);
        conv_done = 1'b1;
        conv_temp = t;
        conv_rh   = h;
        {temp_above, temp_below, rh_above, rh_below} = f;
        @(negedge core_clk);
        conv_done = 1'b0;
        conv_temp = ~t;
        conv_rh   = ~h;
        {temp_above, temp_below, rh_above, rh_below} = ~f;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic sc_reset_values();
        logic [7:0] d;
        host_u.point(ADDR_TEMP_LOW);
        for (int i = 0; i < 10; i++) begin
            host_u.read(d);
            check("reset byte", {8'h00, d}, 16'h0000);
        end
        check("unmapped hit", {15'h0000, reg_hit}, 16'h0000);
        host_u.read(d);
        check("unmapped read", {8'h00, d}, 16'h0000);
        check("drive off", {15'h0000, alert_pin_drive_n}, 16'h0001);
    endtask

    task automatic sc_result_flags();
        logic [7:0] lo;
        logic [7:0] hi;
        convert(14'h2ABC, 14'h1357, 4'b1010);
        host_u.point(ADDR_TEMP_LOW);
        host_u.read(lo);
        host_u.read(hi);
        check("temp result", {hi, lo}, {14'h2ABC, 2'b00});
        host_u.read(lo);
        host_u.read(hi);
        check("rh result", {hi, lo}, {14'h1357, 2'b00});
        host_u.read(lo);
        check("status after result read", {8'h00, lo}, 16'h0050);
        expect_reg("status cleared", ADDR_STATUS, 8'h00);
        convert(14'h0001, 14'h0002, 4'b0101);
        expect_reg("status done", ADDR_STATUS, 8'hA8);
    endtask

    task automatic sc_trim();
        logic [7:0] lo;
        logic [7:0] hi;
        host_u.point(ADDR_TEMP_LOW);
        host_u.write(8'h5A);
        expect_reg("read-only result", ADDR_TEMP_LOW, 8'h04);
        host_u.point(ADDR_TEMP_TRIM);
        host_u.write(8'h01);
        host_u.write(8'h80);
        convert(14'h1000, 14'h2100, 4'b0000);
        host_u.point(ADDR_TEMP_LOW);
        host_u.read(lo);
        host_u.read(hi);
        check("trimmed temp", {hi, lo}, 16'h4040);
        host_u.read(lo);
        host_u.read(hi);
        check("trimmed rh", {hi, lo}, 16'h6400);
        // sums clamp instead of wrapping
        convert(14'h3FFF, 14'h0010, 4'b0000);
        host_u.point(ADDR_TEMP_LOW);
        host_u.read(lo);
        host_u.read(hi);
        check("temp ceiling", {hi, lo}, 16'hFFFC);
        host_u.read(lo);
        host_u.read(hi);
        check("rh floor", {hi, lo}, 16'h0000);
        expect_reg("trim stored", ADDR_TEMP_TRIM, 8'h01);
    endtask

    task automatic sc_peaks_soft_reset();
        host_u.point(ADDR_TEMP_PEAK);
        host_u.write(8'h00);
        host_u.write(8'h00);
        host_u.write(8'h00);
        host_u.write(8'h00);
        host_u.write(8'h00);
        convert(14'h1240, 14'h0800, 4'b0000);
        convert(14'h0FC0, 14'h0A00, 4'b0000);
        expect_reg("temp peak", ADDR_TEMP_PEAK, 8'h49);
        expect_reg("rh peak", ADDR_RH_PEAK, 8'h28);
        host_u.point(ADDR_TEMP_PEAK);
        host_u.write(8'h00);
        expect_reg("peak erased", ADDR_TEMP_PEAK, 8'h00);
        host_u.point(ADDR_TEMP_TRIM);
        host_u.write(8'h33);
        host_u.point(ADDR_CONFIG);
        host_u.write(8'h80);
        check("reload pulse", {15'h0000, nv_reload}, 16'h0001);
        @(negedge core_clk);
        check("reload ends", {15'h0000, nv_reload}, 16'h0000);
        expect_reg("rh peak soft", ADDR_RH_PEAK, 8'h00);
        expect_reg("trim soft", ADDR_TEMP_TRIM, 8'h00);
        expect_reg("config self clear", ADDR_CONFIG, 8'h00);
    endtask

    task automatic sc_alert();
        host_u.point(ADDR_IRQ_EN);
        host_u.write(8'hFF);
        host_u.point(ADDR_CONFIG);
        host_u.write(8'h06);
        @(negedge core_clk);
        check("cfg bits", {9'h000, cfg_bits}, 16'h0006);
        check("drive on", {15'h0000, alert_pin_drive_n}, 16'h0000);
        expect_reg("enables", ADDR_IRQ_EN, 8'hF8);
        convert(14'h0100, 14'h0100, 4'b1111);
        @(negedge core_clk);
        check("alert done", {15'h0000, alert_pin}, 16'h0001);
        expect_reg("status full", ADDR_STATUS, 8'hF8);
        @(negedge core_clk);
        check("alert cleared", {15'h0000, alert_pin}, 16'h0000);
        host_u.point(ADDR_IRQ_EN);
        host_u.write(8'h38);
        convert(14'h0100, 14'h0100, 4'b0111);
        @(negedge core_clk);
        check("alert gated", {15'h0000, alert_pin}, 16'h0000);
        expect_reg("status gated", ADDR_STATUS, 8'hB8);
        convert(14'h0100, 14'h0100, 4'b1000);
        @(negedge core_clk);
        check("alert temp high", {15'h0000, alert_pin}, 16'h0001);
        host_u.point(ADDR_CONFIG);
        host_u.write(8'h04);
        @(negedge core_clk);
        check("alert low active", {15'h0000, alert_pin}, 16'h0000);
    endtask

    // a read and a new event on one edge: the event must survive
    task automatic sc_coincident();
        logic [7:0] d;
        expect_reg("status drain", ADDR_STATUS, 8'hC0);
        host_u.point(ADDR_STATUS);
        fork
            host_u.read(d);
            convert(14'h0100, 14'h0100, 4'b0001);
        join
        check("snapshot", {8'h00, d}, 16'h0000);
        expect_reg("event kept", ADDR_STATUS, 8'h88);
    endtask

    // a second power-up reset in mid-run; unlike soft reset it homes the pointer
    task automatic sc_hard_reset();
        host_u.point(8'h0B);
        check("unmapped pointer", {15'h0000, reg_hit}, 16'h0000);
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        check("reset hit", {15'h0000, reg_hit}, 16'h0001);
        check("reset alert", {15'h0000, alert_pin}, 16'h0001);
        check("reset drive", {15'h0000, alert_pin_drive_n}, 16'h0001);
        check("reset cfg", {9'h000, cfg_bits}, 16'h0000);
        expect_reg("peak power-up", ADDR_TEMP_PEAK, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        core_clk   = 1'b0;
        sys_rst    = 1'b1;
        conv_done  = 1'b0;
        conv_temp  = 14'h0000;
        conv_rh    = 14'h0000;
        {temp_above, temp_below, rh_above, rh_below} = 4'h0;
        num_errors = 0;
        n_tests    = 0;
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        sc_reset_values();
        sc_result_flags();
        sc_trim();
        sc_peaks_soft_reset();
        sc_alert();
        sc_coincident();
        sc_hard_reset();
        tally_and_finish();
    end
endmodule
